/* fpe_cfg.svh */
// What this block does
// - Host access waits 20 us after a reset pulse; ready not sampled
// - Status reads pulsed by OE or CE; this block pulses OE only, CE held low
// - Protect: addr bits 6=0, 1=1, 0=0
// - Unprotect: addr bits 6=1, 1=1, 0=0
// - Elevated reset level 4 us before writes
// - Program is four cycles, bypass two
// - Toggle reads any address, poll valid
// - CE-timed writes equal WE-timed writes
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH
// Software register offsets
`define FPE_REG_CTRL    4'h0
`define FPE_REG_ADDR    4'h1
`define FPE_REG_DATA    4'h2
`define FPE_REG_STATUS  4'h3
`define FPE_REG_IRQ     4'h4
`define FPE_REG_MASK    4'h5
`define FPE_REG_RDATA   4'h6
`define FPE_REG_SECTOR  4'h7
// Control field positions
`define FPE_CTRL_CMD_LO 0
`define FPE_CTRL_BYPASS 4
`define FPE_CTRL_CE_WR  5
`define FPE_CTRL_POLL   6
// Interrupt bit positions
`define FPE_IRQ_DONE    0
`define FPE_IRQ_TMO     1
// Timing, clock period in ps
`define FPE_CLK_PS      50000
`define FPE_PULSE_NS    50
`define FPE_BUSY_NS     90
`define FPE_TRSP_NS     4000
`define FPE_TREADY_NS   20000
`define FPE_TRP_NS      500
// Command bytes and unlock addresses
`define FPE_UNLK_A1     21'h000555
`define FPE_UNLK_A2     21'h0002aa
`define FPE_UNLK_D1     8'haa
`define FPE_UNLK_D2     8'h55
`define FPE_CMD_PROG    8'ha0
`define FPE_CMD_ERASE   8'h80
`define FPE_CMD_SECT    8'h30
`define FPE_CMD_SUSP    8'hb0
`define FPE_CMD_RESUME  8'h30
`define FPE_CMD_RESET   8'hf0
// Sector protect address patterns
`define FPE_PROT_PAT    21'h000002
`define FPE_UNPROT_PAT  21'h000042
`define FPE_RST_VAL     8'h00
`endif

/* fpe_pkg.sv */
package fpe_pkg;
   // Orders software can give
   typedef enum logic [3:0] {
      FPE_OP_NONE    = 4'h0,
      FPE_OP_PROG    = 4'h1,
      FPE_OP_ERASE   = 4'h2,
      FPE_OP_READ    = 4'h3,
      FPE_OP_SUSPEND = 4'h4,
      FPE_OP_RESUME  = 4'h5,
      FPE_OP_PROTECT = 4'h6,
      FPE_OP_UNPROT  = 4'h7,
      FPE_OP_HWRESET = 4'h8
   } fpe_op_t;
   // Controller sequencer states
   typedef enum logic [3:0] {
      FPE_IDLE  = 4'h0,
      FPE_WSET  = 4'h1,
      FPE_WPUL  = 4'h2,
      FPE_WGAP  = 4'h3,
      FPE_BUSYW = 4'h4,
      FPE_WAIT  = 4'h5,
      FPE_RSET  = 4'h6,
      FPE_RCAP  = 4'h7,
      FPE_RSTP  = 4'h8,
      FPE_VIDW  = 4'h9
   } fpe_state_t;
   // Full controller state
   typedef struct packed {
      logic [1:0]  rs;
      fpe_state_t  st;
      fpe_op_t     op;
      logic [2:0]  step;
      logic [2:0]  nsteps;
      logic [15:0] cnt;
      logic [31:0] tmo;
      logic [20:0] addr;
      logic [20:0] sector;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic [7:0]  last;
      logic        bypass;
      logic        ce_wr;
      logic        poll_mode;
      logic [1:0]  irq;
      logic [1:0]  mask;
      logic [7:0]  bus_rd;
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic        dq_oe_n;
      logic        rst_n;
      logic        vid;
      logic [20:0] a;
      logic [7:0]  dq;
      logic [1:0]  rb_s;
      logic [15:0] dq_s;
      logic        irq_out;
   } fpe_regs_t;
endpackage

/* fpe_ctrl.sv */
`timescale 1ns/1ps
`include "fpe_cfg.svh"
module fpe_ctrl
   import fpe_pkg::*;
#(
   parameter int TMO_CYCLES = 1200000000
) (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic [3:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic      [31:0] sw_rdata,
   output logic             irq,
   output logic             flash_ce_n,
   output logic             flash_we_n,
   output logic             flash_oe_n,
   output logic             flash_reset_n,
   output logic             flash_reset_hv,
   output logic      [20:0] flash_addr,
   output logic      [7:0]  flash_dq_o,
   output logic             flash_dq_oe_n,
   input  wire logic [7:0]  flash_dq_i,
   input  wire logic        ready_busy_n
);
   // Cycle counts derived from times, rounded up; BUSY_CY adds one more
   localparam int PULSE_CY =
      (`FPE_PULSE_NS * 1000 + `FPE_CLK_PS - 1) / `FPE_CLK_PS;
   localparam int BUSY_CY =
      (`FPE_BUSY_NS * 1000 + `FPE_CLK_PS - 1) / `FPE_CLK_PS + 1;
   localparam int TRSP_CY =
      (`FPE_TRSP_NS * 1000 + `FPE_CLK_PS - 1) / `FPE_CLK_PS;
   localparam int TREADY_CY =
      (`FPE_TREADY_NS * 1000 + `FPE_CLK_PS - 1) / `FPE_CLK_PS;
   localparam int TRP_CY =
      (`FPE_TRP_NS * 1000 + `FPE_CLK_PS - 1) / `FPE_CLK_PS;

   fpe_regs_t r;       // Registered state
   fpe_regs_t next_r;  // Next state
   logic      rb_sync; // Synchronised ready/busy
   logic [7:0] dq_sync;// Synchronised data pins

   assign rb_sync = r.rb_s[1];
   assign dq_sync = r.dq_s[15:8];

   // Address and data of command cycle number s
   function automatic logic [28:0] cyc(input fpe_op_t op,
                                       input logic byp,
                                       input logic [2:0] s,
                                       input logic [20:0] a,
                                       input logic [7:0] d);
      logic [7:0] cd;
      begin
         cd = `FPE_CMD_PROG;
         if (op == FPE_OP_ERASE) begin
            cd = `FPE_CMD_ERASE;
         end
         if (byp && op == FPE_OP_PROG) begin
            cyc = (s == 3'd0) ? {`FPE_UNLK_A1, cd} : {a, d};
         end else if (op == FPE_OP_SUSPEND) begin
            cyc = {a, `FPE_CMD_SUSP};
         end else if (op == FPE_OP_RESUME) begin
            cyc = {a, `FPE_CMD_RESUME};
         end else if (op == FPE_OP_PROTECT || op == FPE_OP_UNPROT) begin
            // Single write with the pattern, pin raised
            cyc = {a, d};
         end else begin
            case (s)
               3'd0:    cyc = {`FPE_UNLK_A1, `FPE_UNLK_D1};
               3'd1:    cyc = {`FPE_UNLK_A2, `FPE_UNLK_D2};
               3'd2:    cyc = {`FPE_UNLK_A1, cd};
               3'd3:    cyc = (op == FPE_OP_PROG) ? {a, d}
                                 : {`FPE_UNLK_A1, `FPE_UNLK_D1};
               3'd4:    cyc = {`FPE_UNLK_A2, `FPE_UNLK_D2};
               default: cyc = {a, `FPE_CMD_SECT};
            endcase
         end
      end
   endfunction

   // Next-state logic for whole controller
   always_comb begin
      logic [28:0] c;
      logic [3:0]  ev;
      c = '0;
      ev = '0;
      next_r = r;
      next_r.rs = {r.rs[0], 1'b1};
      // Two-stage pin synchronisers
      next_r.rb_s = {r.rb_s[0], ready_busy_n};
      next_r.dq_s = {r.dq_s[7:0], flash_dq_i};
      next_r.bus_rd = 8'h00;
      if (r.cnt != 16'h0) begin
         next_r.cnt = r.cnt - 16'h1;
      end
      if (r.tmo != 32'h0) begin
         next_r.tmo = r.tmo - 32'h1;
      end
      // Software register writes
      if (sw_wr) begin
         case (sw_addr)
            `FPE_REG_ADDR:   next_r.addr = sw_wdata[20:0];
            `FPE_REG_DATA:   next_r.wdata = sw_wdata[7:0];
            `FPE_REG_SECTOR: next_r.sector = sw_wdata[20:0];
            `FPE_REG_MASK:   next_r.mask = sw_wdata[1:0];
            `FPE_REG_IRQ:    next_r.irq = r.irq & ~sw_wdata[1:0];
            `FPE_REG_CTRL: begin
               next_r.bypass = sw_wdata[`FPE_CTRL_BYPASS];
               next_r.ce_wr = sw_wdata[`FPE_CTRL_CE_WR];
               next_r.poll_mode = sw_wdata[`FPE_CTRL_POLL];
               if (r.st == FPE_IDLE) begin
                  next_r.op = fpe_op_t'(sw_wdata[3:0]);
               end
            end
            default: ;
         endcase
      end
      // Software register reads, data next cycle
      if (sw_rd) begin
         case (sw_addr)
            `FPE_REG_STATUS: next_r.bus_rd =
               {4'h0, rb_sync, r.st != FPE_IDLE, r.vid, r.rst_n};
            `FPE_REG_IRQ:    next_r.bus_rd = {6'h0, r.irq};
            `FPE_REG_MASK:   next_r.bus_rd = {6'h0, r.mask};
            `FPE_REG_RDATA:  next_r.bus_rd = r.rdata;
            `FPE_REG_DATA:   next_r.bus_rd = r.wdata;
            default:         next_r.bus_rd = 8'h00;
         endcase
      end
      case (r.st)
         FPE_IDLE: begin
            next_r.ce_n = 1'b1;
            next_r.we_n = 1'b1;
            next_r.oe_n = 1'b1;
            next_r.dq_oe_n = 1'b1;
            next_r.step = 3'd0;
            if (sw_wr && sw_addr == `FPE_REG_CTRL && r.rs[1]) begin
               case (fpe_op_t'(sw_wdata[3:0]))
                  FPE_OP_PROG: begin
                     next_r.nsteps = sw_wdata[`FPE_CTRL_BYPASS]
                                     ? 3'd1 : 3'd3;
                     next_r.st = FPE_WSET;
                  end
                  FPE_OP_ERASE: begin
                     next_r.nsteps = 3'd5;
                     next_r.st = FPE_WSET;
                  end
                  FPE_OP_SUSPEND, FPE_OP_RESUME: begin
                     next_r.nsteps = 3'd0;
                     next_r.st = FPE_WSET;
                  end
                  FPE_OP_PROTECT: begin
                     next_r.rst_n = 1'b1;
                     next_r.vid = 1'b1;
                     next_r.a = `FPE_PROT_PAT | r.sector;
                     next_r.cnt = 16'(TRSP_CY);
                     next_r.st = FPE_VIDW;
                  end
                  FPE_OP_UNPROT: begin
                     next_r.vid = 1'b1;
                     next_r.a = `FPE_UNPROT_PAT | r.sector;
                     next_r.cnt = 16'(TRSP_CY);
                     next_r.st = FPE_VIDW;
                  end
                  FPE_OP_READ: begin
                     next_r.st = FPE_RSET;
                  end
                  FPE_OP_HWRESET: begin
                     next_r.rst_n = 1'b0;
                     next_r.cnt = 16'(TRP_CY);
                     next_r.st = FPE_RSTP;
                  end
                  default: ;
               endcase
            end
         end
         FPE_VIDW: begin
            if (r.cnt == 16'h0) begin
               // Pin stays raised through the write
               next_r.nsteps = 3'd0;
               next_r.st = FPE_WSET;
            end
         end
         // Set address, data and strobes low together; pulse held next
         FPE_WSET: begin
            c = cyc(r.op, r.bypass, r.step, r.op == FPE_OP_ERASE
                    ? r.sector : (r.vid ? r.a : r.addr), r.wdata);
            next_r.a = c[28:8];
            next_r.dq = c[7:0];
            next_r.dq_oe_n = 1'b0;
            next_r.oe_n = 1'b1;
            if (r.ce_wr) begin
               next_r.we_n = 1'b0;
               next_r.ce_n = 1'b0;
            end else begin
               next_r.ce_n = 1'b0;
               next_r.we_n = 1'b0;
            end
            next_r.cnt = 16'(PULSE_CY);
            next_r.st = FPE_WPUL;
         end
         FPE_WPUL: begin
            if (r.cnt == 16'h0) begin
               if (r.ce_wr) begin
                  next_r.ce_n = 1'b1;
               end else begin
                  next_r.we_n = 1'b1;
               end
               next_r.cnt = 16'(PULSE_CY);
               next_r.st = FPE_WGAP;
            end
         end
         FPE_WGAP: begin
            next_r.we_n = 1'b1;
            next_r.ce_n = 1'b1;
            if (r.cnt == 16'h0) begin
               next_r.dq_oe_n = 1'b1;
               if (r.step == r.nsteps) begin
                  next_r.step = 3'd0;
                  next_r.cnt = 16'(BUSY_CY);
                  next_r.st = (r.op == FPE_OP_PROG ||
                               r.op == FPE_OP_ERASE)
                              ? FPE_BUSYW : FPE_IDLE;
                  next_r.tmo = 32'(TMO_CYCLES);
                  // Protect write done, drop the raised pin
                  if (r.vid) begin
                     next_r.vid = 1'b0;
                     ev[0] = 1'b1;
                  end
               end else begin
                  next_r.step = r.step + 3'd1;
                  next_r.st = FPE_WSET;
               end
            end
         end
         FPE_BUSYW: begin
            if (r.cnt == 16'h0) begin
               // Two cycles before the first valid poll sample
               next_r.cnt = 16'h2;
               next_r.st = FPE_WAIT;
            end
         end
         FPE_WAIT: begin
            if (r.poll_mode) begin
               next_r.a = r.addr;
               next_r.ce_n = 1'b0;
               next_r.oe_n = ~r.oe_n;
               // Judge only data taken while outputs enabled
               if (!r.oe_n && r.cnt == 16'h0 &&
                   dq_sync[7] == r.wdata[7]) begin
                  next_r.st = FPE_RSET;
                  ev[0] = 1'b1;
               end
            end else if (rb_sync) begin
               next_r.st = FPE_RSET;
               ev[0] = 1'b1;
            end
            if (r.tmo == 32'h0) begin
               ev[1] = 1'b1;
               next_r.st = FPE_IDLE;
            end
         end
         FPE_RSET: begin
            next_r.a = r.addr;
            next_r.ce_n = 1'b0;
            next_r.oe_n = 1'b0;
            next_r.dq_oe_n = 1'b1;
            next_r.cnt = 16'(PULSE_CY + 2);
            next_r.st = FPE_RCAP;
         end
         FPE_RCAP: begin
            if (r.cnt == 16'h0) begin
               next_r.rdata = dq_sync;
               next_r.oe_n = 1'b1;
               next_r.ce_n = 1'b1;
               next_r.st = FPE_IDLE;
            end
         end
         FPE_RSTP: begin
            if (r.cnt == 16'h0) begin
               if (!r.rst_n) begin
                  next_r.rst_n = 1'b1;
                  next_r.cnt = 16'(TREADY_CY);
               end else begin
                  next_r.st = FPE_IDLE;
                  ev[0] = 1'b1;
               end
            end
         end
         default: next_r.st = FPE_IDLE;
      endcase
      // Sticky events, set wins over clear
      next_r.irq = next_r.irq | ev[1:0];
      next_r.irq_out = |(next_r.irq & next_r.mask);
   end

   // Register state, async reset to constants
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.st <= FPE_IDLE;
         r.ce_n <= 1'b1;
         r.we_n <= 1'b1;
         r.oe_n <= 1'b1;
         r.dq_oe_n <= 1'b1;
         r.rst_n <= 1'b1;
         r.rb_s <= 2'b11;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from state flops
   assign sw_rdata = {24'h0, r.bus_rd};
   assign irq = r.irq_out;
   assign flash_ce_n = r.ce_n;
   assign flash_we_n = r.we_n;
   assign flash_oe_n = r.oe_n;
   assign flash_reset_n = r.rst_n;
   assign flash_reset_hv = r.vid;
   assign flash_addr = r.a;
   assign flash_dq_o = r.dq;
   assign flash_dq_oe_n = r.dq_oe_n;
endmodule

/* fpe_monitor.sv */
`timescale 1ns/1ps
`include "fpe_cfg.svh"
// Pin and register-port checks beside the controller
module fpe_monitor (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic [3:0]  sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic        sw_wr,
   input wire logic        sw_rd,
   input wire logic [31:0] sw_rdata,
   input wire logic        irq,
   input wire logic        flash_ce_n,
   input wire logic        flash_we_n,
   input wire logic        flash_oe_n,
   input wire logic        flash_reset_n,
   input wire logic        flash_reset_hv,
   input wire logic [20:0] flash_addr,
   input wire logic        flash_dq_oe_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire        wr_cyc = !flash_ce_n && !flash_we_n; // Device write window
   logic [7:0] hv_cnt;                              // Cycles at high level
   // Time the raised reset pin; saturates so it never wraps
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         hv_cnt <= 8'h00;
      else if (!flash_reset_hv)
         hv_cnt <= 8'h00;
      else if (hv_cnt != 8'hff)
         hv_cnt <= hv_cnt + 8'h01;
   end
   // A write made with the pin raised
   sequence hv_wr_s;
      flash_reset_hv && wr_cyc;
   endsequence
   // Start of a device reset pulse
   sequence rst_low_s;
      $fell(flash_reset_n);
   endsequence
   idle_pins_a: assert property ($rose(resetn) |-> flash_ce_n &&
      flash_we_n && flash_oe_n && flash_dq_oe_n) else $error("pins busy");
   no_fight_a: assert property (!flash_dq_oe_n |-> flash_oe_n)
      else $error("drive during read");
   read_ctl_a: assert property (!flash_oe_n |-> flash_we_n
      && flash_dq_oe_n) else $error("read strobe with write");
   wr_drive_a: assert property (wr_cyc |-> !flash_dq_oe_n
      && flash_oe_n) else $error("write without data");
   rdata_idle_a: assert property (!sw_rd |=> sw_rdata == 32'h0)
      else $error("read data outside slot");
   mask_off_a: assert property (sw_wr && sw_addr == `FPE_REG_MASK &&
      sw_wdata[1:0] == 2'b00 |-> ##2 !irq) else $error("masked irq");
   hv_setup_a: assert property (hv_wr_s |-> hv_cnt >= 8'h50)
      else $error("write too soon after raise");
   prot_pat_a: assert property (hv_wr_s |-> flash_addr[1:0] == 2'b10)
      else $error("protect address pattern");
   rst_width_a: assert property (rst_low_s |=> !flash_reset_n [*8])
      else $error("reset pulse short");
endmodule

/* fpe_flash_model.sv */
`timescale 1ns/1ps
// Behavioural byte-wide flash on the far side
module fpe_flash_model #(
   parameter int PROG_NS  = 2000, // Shortened byte program
   parameter int ERASE_NS = 6000  // Shortened sector erase
) (
   input  wire logic        ce_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic        reset_n,
   input  wire logic        reset_hv,
   input  wire logic [20:0] addr,
   input  wire logic [7:0]  dq_in,
   input  wire logic        hang,
   output logic      [7:0]  dq_out,
   output logic             dq_drv,
   output logic             ready_busy_n,
   output logic      [20:0] prot_addr,
   output logic      [7:0]  nwr
);
   logic [7:0]  mem [int]; // Sparse array, unset reads erased
   logic        pgm_arm;   // Next write is program data
   logic        ers_arm;   // Erase setup seen
   logic        busy;      // Algorithm running
   logic        tog;       // Busy toggle bit
   logic [7:0]  pdata;     // Byte being programmed
   logic [20:0] pa;        // Address latched at the write
   // either strobe rising ends a write
   wire         wr_n = ce_n | we_n;
   wire         rd_n = ce_n | oe_n;
   function automatic logic [7:0] rd_mem(input logic [20:0] a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction
   initial begin
      {pgm_arm, ers_arm, busy, tog} = 4'h0;
      {pdata, prot_addr, nwr} = 37'h0;
      ready_busy_n = 1'b1;
   end
   assign dq_drv = !rd_n;
   // no suspended sector here, so bit 2 stays still
   // status while busy, stored data after
   always @* dq_out = busy ? {~pdata[7], tog, 6'h00} : rd_mem(addr);
   // Each read pulse while busy flips the toggle bit
   always @(posedge rd_n) if (busy) tog = ~tog;
   // Command decode; blocks while the algorithm runs
   always @(posedge wr_n) begin : wr_blk
      if (reset_n === 1'b1 && $time > 100) begin
         nwr = nwr + 8'h01;
         pa  = addr;
         if (reset_hv)
            prot_addr = addr;
         if (pgm_arm || (ers_arm && dq_in == 8'h30)) begin
            busy         = 1'b1;
            ready_busy_n = 1'b0;
            pdata        = pgm_arm ? dq_in : 8'hff;
            if (pgm_arm) begin
               #(PROG_NS);
               mem[pa] = rd_mem(pa) & pdata;
            end else begin
               foreach (mem[k])
                  if (k[20:16] == pa[20:16]) mem[k] = 8'h00;
               #(ERASE_NS);
               foreach (mem[k])
                  if (k[20:16] == pa[20:16]) mem[k] = 8'hff;
            end
            {pgm_arm, ers_arm} = 2'b00;
            // Stuck on purpose when the bench asks
            wait (!hang);
            busy         = 1'b0;
            ready_busy_n = 1'b1;
         end else begin
            pgm_arm = (dq_in == 8'ha0);
            ers_arm = ers_arm || (dq_in == 8'h80);
         end
      end
   end
   // reset pin drops any algorithm at once
   always @(negedge reset_n) begin
      disable wr_blk;
      {pgm_arm, ers_arm, busy} = 3'h0;
      ready_busy_n = 1'b1;
   end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`include "fpe_cfg.svh"
// Self-checking bench for the flash controller
module tb_top;
   import fpe_pkg::*;
   logic        clk_sys;     // 20 MHz clock
   logic        resetn;      // Active low reset
   logic [3:0]  sw_addr;
   logic [31:0] sw_wdata;
   logic        sw_wr;
   logic        sw_rd;
   logic        hang;        // Holds the model busy
   logic [31:0] v;           // Last register read
   int          fail_count;
   int          checks_done;
   logic [3:0]  mode_tab [4] = '{4'h0, 4'h1, 4'h2, 4'h4}; // Write modes
   wire  [31:0] sw_rdata;
   wire         irq, ce_n, we_n, oe_n, rst_n, hv, dq_oe_n, rb_n, m_drv;
   wire  [20:0] f_addr, p_addr;
   wire  [7:0]  c_dq, m_dq, n_wr;
   // Shared DQ; undriven it shows the inverse of the model's data output
   wire  [7:0]  dq_bus = !dq_oe_n ? c_dq : (m_drv ? m_dq : ~m_dq);
   fpe_ctrl #(.TMO_CYCLES(2000)) i_dut (
      .clk_sys(clk_sys), .resetn(resetn), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .irq(irq), .flash_ce_n(ce_n),
      .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_reset_n(rst_n),
      .flash_reset_hv(hv), .flash_addr(f_addr), .flash_dq_o(c_dq),
      .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_bus), .ready_busy_n(rb_n));
   fpe_flash_model i_flash (
      .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_n(rst_n),
      .reset_hv(hv), .addr(f_addr), .dq_in(dq_bus), .hang(hang),
      .dq_out(m_dq), .dq_drv(m_drv), .ready_busy_n(rb_n),
      .prot_addr(p_addr), .nwr(n_wr));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One-cycle write; ends just past the edge so strobes never collide
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge clk_sys);
      sw_wr    <= 1'b0;
      #1;
   endtask
   // Read data is taken in the single cycle after the strobe
   task automatic rd(input logic [3:0] a);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge clk_sys);
      sw_rd   <= 1'b0;
      #1 v = sw_rdata;
   endtask
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      #1 check({31'h0, irq}, 32'h1);
   endtask
   // Load address and data, start an order, await and clear its end
   task automatic op(input logic [31:0] c, input logic [20:0] a,
                     input logic [7:0] d);
      wr(`FPE_REG_ADDR, {11'h0, a});
      wr(`FPE_REG_SECTOR, {11'h0, a});
      wr(`FPE_REG_DATA, {24'h0, d});
      wr(`FPE_REG_CTRL, c);
      wait_irq(5000);
      rd(`FPE_REG_IRQ);
      check(v, 32'h1);
      wr(`FPE_REG_IRQ, 32'h1);
      repeat (2) @(posedge clk_sys);
      #1 check({31'h0, irq}, 32'h0);
   endtask
   task automatic close_out;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {resetn, sw_addr, sw_wdata, sw_wr, sw_rd, hang} = 40'h0;
      {fail_count, checks_done} = 64'h0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(`FPE_REG_STATUS);
      check(v, 32'h9);
      rd(4'hf);
      check(v, 32'h0);
      rd(`FPE_REG_MASK);
      check(v, 32'h0);
      wr(`FPE_REG_MASK, 32'h3);
      // Single-write orders reach the device once each
      wr(`FPE_REG_CTRL, {28'h0, FPE_OP_SUSPEND});
      repeat (8) @(posedge clk_sys);
      wr(`FPE_REG_CTRL, {28'h0, FPE_OP_RESUME});
      repeat (8) @(posedge clk_sys);
      check({24'h0, n_wr}, 32'h2);
      // Plain, bypass, CE-timed and polled programs
      for (int i = 0; i < 4; i++) begin
         op({24'h0, mode_tab[i], FPE_OP_PROG}, 21'h012340 + 21'(i),
            8'h5a + 8'(i));
         if (i == 0)
            check({24'h0, n_wr}, 32'h6);
         rd(`FPE_REG_RDATA);
         check(v, {24'h0, 8'h5a + 8'(i)});
      end
      op({28'h0, FPE_OP_ERASE}, 21'h012000, 8'h00);
      // Plain read raises no event; let the fetch finish
      wr(`FPE_REG_ADDR, 32'h00012341);
      wr(`FPE_REG_CTRL, {28'h0, FPE_OP_READ});
      repeat (8) @(posedge clk_sys);
      rd(`FPE_REG_STATUS);
      check(v, 32'h9);
      rd(`FPE_REG_RDATA);
      check(v, 32'hff);
      op({28'h0, FPE_OP_PROTECT}, 21'h030000, 8'h00);
      check({29'h0, p_addr[6], p_addr[1:0]}, 32'h2);
      op({28'h0, FPE_OP_UNPROT}, 21'h030000, 8'h00);
      check({29'h0, p_addr[6], p_addr[1:0]}, 32'h6);
      // Device stuck busy: masked timeout, then unmasked
      hang <= 1'b1;
      wr(`FPE_REG_MASK, 32'h0);
      wr(`FPE_REG_DATA, 32'h11);
      wr(`FPE_REG_CTRL, {28'h0, FPE_OP_PROG});
      repeat (2300) @(posedge clk_sys);
      #1 check({31'h0, irq}, 32'h0);
      rd(`FPE_REG_IRQ);
      check({31'h0, v[1]}, 32'h1);
      wr(`FPE_REG_MASK, 32'h3);
      wait_irq(4);
      wr(`FPE_REG_IRQ, 32'h3);
      op({28'h0, FPE_OP_HWRESET}, 21'h0, 8'h00);
      hang <= 1'b0;
      rd(`FPE_REG_STATUS);
      check(v, 32'h9);
      op({28'h0, FPE_OP_PROG}, 21'h050007, 8'h3c);
      rd(`FPE_REG_RDATA);
      check(v, 32'h3c);
      close_out();
   end
   // Cut a hang short well past the expected run
   initial begin
      #(50 * 60000);
      fail_count++;
      close_out();
   end
endmodule
bind fpe_ctrl fpe_monitor i_mon (
   .clk_sys(clk_sys), .resetn(resetn), .sw_addr(sw_addr),
   .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
   .sw_rdata(sw_rdata), .irq(irq), .flash_ce_n(flash_ce_n),
   .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
   .flash_reset_n(flash_reset_n), .flash_reset_hv(flash_reset_hv),
   .flash_addr(flash_addr), .flash_dq_oe_n(flash_dq_oe_n));
